// ### rtl/lcm_core.sv
/*
 * Timing and display-memory core of a multiplexed LCD segment driver:
 * internal clock and frame timing, cascade synchronisation, backplane
 * mapping, 80x4 display memory with pointer-driven byte loading and a
 * cascade subaddress counter, all behind an Avalon-MM slave.
 * Assumes the clock, sync and strap pins are asynchronous to SYS_CLK_I;
 * the open-drain sync wire is resolved outside.
 */
// The Avalon-MM interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - internal clock: oscillator/64 or external clock
// - frame rate is internal clock/24
// - select low: internal oscillator, drive clock out
// - select high: clock pin is an input
// - sync line aligns frames and transfers
// - three-backplane: line 3 copies line 1
// - two-backplane: 2 copies 0, 3 copies 1
// - static: all backplane lines identical
// - 80 segment lines from phase and data
// - 80x4 memory, 1 means element on
// - row n shown while backplane n active
// - static: eight bits; two-backplane: pairs
// - three-backplane: triples, last row-3 kept
// - four-backplane: two columns of four bits
// - byte written at loaded pointer location
// - pointer advances 8, 4, 3 or 2
// - store a bit only when its subaddress (counter, +1 if wrapped) matches straps
// - mismatch: discard those bits, still advance pointer
// - pointer overflow bumps subaddress counter
// - last driver discards and refuses overflow bytes
module lcm_core (
	input  wire logic                 SYS_CLK_I,
	input  wire logic                 RESETN_I,
	input  wire logic                 CE_I,
	input  wire lcm_pkg::lcm_avm_req_t AVS_REQ_I,
	output logic [31:0]               AVS_READDATA_O,
	output logic                      AVS_WAITREQUEST_O,
	input  wire logic                 OSC_SEL_I,
	input  wire logic                 CLK_PIN_I,
	output logic                      CLK_PIN_O,
	output logic                      CLK_PIN_OE_O,
	input  wire logic                 SYNC_N_PIN_I,
	output logic                      SYNC_N_PIN_O,
	output logic                      SYNC_N_PIN_OE_O,
	input  wire logic [2:0]           HW_SUBADDR_I,
	output logic [3:0]                BACKPLANE_LINE_O,
	output logic [79:0]               SEGMENT_LINE_O,
	output logic                      FRAME_RATE_O
);
	import lcm_pkg::*;

	lcm_state_t s;
	lcm_state_t next_s;

	//////////////////////////////////////////////////////////////////////////
	// helpers

	// memory rows filled by one column of an incoming byte
	function automatic int bits_per_col(input lcm_mode_t m);
		unique case (m)
			MODE_STATIC: return 1;
			MODE_MUX2:   return 2;
			MODE_MUX3:   return 3;
			MODE_MUX4:   return 4;
		endcase
	endfunction : bits_per_col

	// active row for a frame phase; a frame is split evenly over the rows
	function automatic logic [1:0] row_of(input logic [4:0] ph, input lcm_mode_t m);
		unique case (m)
			MODE_STATIC: return 2'h0;
			MODE_MUX2:   return (ph >= PHASE_HALF) ? 2'h1 : 2'h0;
			MODE_MUX3:   return 2'(ph / 5'h08);
			MODE_MUX4:   return 2'(ph / 5'h06);
		endcase
	endfunction : row_of

	// which backplane lines are active for a row
	function automatic logic [3:0] bp_map(input logic [1:0] r, input lcm_mode_t m);
		unique case (m)
			MODE_STATIC: return 4'hf;
			MODE_MUX2:   return (r == 2'h0) ? 4'h5 : 4'ha;
			MODE_MUX3:   return (r == 2'h0) ? 4'h1 :
			                    (r == 2'h1) ? 4'ha : 4'h4;
			MODE_MUX4:   return 4'h1 << r;
		endcase
	endfunction : bp_map

	//////////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb begin
		logic       tick;
		logic [7:0] col;
		logic [7:0] sum;
		logic [2:0] sub;
		logic       wrapped;
		logic       hit;
		int         nb;
		tick    = 1'b0;
		col     = 8'h00;
		sum     = 8'h00;
		sub     = 3'h0;
		wrapped = 1'b0;
		hit     = 1'b0;
		nb      = bits_per_col(s.mode);
		next_s  = s;

		// two-flop synchronisers; first stage feeds only the second
		next_s.osc_sel_s1 = OSC_SEL_I;
		next_s.osc_sel_s2 = s.osc_sel_s1;
		next_s.clk_s1     = CLK_PIN_I;
		next_s.clk_s2     = s.clk_s1;
		next_s.clk_prev   = s.clk_s2;
		next_s.sync_s1    = SYNC_N_PIN_I;
		next_s.sync_s2    = s.sync_s1;
		next_s.sync_prev  = s.sync_s2;
		next_s.hw_s1      = HW_SUBADDR_I;
		next_s.hw_s2      = s.hw_s1;

		// internal clock tick: own oscillator divided down, or external edge
		if (!s.osc_sel_s2) begin
			if (s.osc_cnt == 11'(OSC_TICK_CYC - 1)) begin
				next_s.osc_cnt = 11'h000;
				next_s.div_cnt = s.div_cnt + 6'h01;
				tick           = (s.div_cnt == 6'(OSC_PRE_DIV - 1));
			end else begin
				next_s.osc_cnt = s.osc_cnt + 11'h001;
			end
		end else begin
			tick = s.clk_s2 && !s.clk_prev;
		end
		next_s.clk_out = s.div_cnt[5];                          // square wave for cascaded drivers
		next_s.clk_oe  = !s.osc_sel_s2;

		// frame phase; a falling sync edge from another driver restarts it
		if (tick) begin
			next_s.phase = (s.phase == PHASE_MAX) ? 5'h00 : s.phase + 5'h01;
		end else if (s.sync_prev && !s.sync_s2 && !s.sync_oe) begin
			next_s.phase = 5'h00;
		end
		// pull the sync wire low through phase 0 so the cascade restarts together
		next_s.sync_oe = (next_s.phase == 5'h00);
		next_s.frame   = (next_s.phase < PHASE_HALF);

		// row selection, backplane mapping and memory-to-segment transfer
		next_s.row = row_of(next_s.phase, s.mode);
		next_s.bp  = bp_map(next_s.row, s.mode);
		for (int c = 0; c < NUM_COLS; c++) begin
			next_s.seg[c] = s.ram[c][next_s.row];
		end

		// Avalon-MM slave: every access answers one cycle after it is seen
		next_s.waitreq = 1'b1;
		if ((AVS_REQ_I.read || AVS_REQ_I.write) && s.waitreq) begin
			next_s.waitreq = 1'b0;
			next_s.rdata   = 32'h0000_0000;                     // unmapped reads give zero
			if (AVS_REQ_I.read) begin
				unique case (AVS_REQ_I.address)
					REG_CTRL: begin
						next_s.rdata[CTRL_MODE_LSB +: 2] = s.mode;
						next_s.rdata[CTRL_LAST_BIT]      = s.last_dev;
					end
					REG_DPTR:   next_s.rdata[STAT_DP_LSB +: 7]  = s.dp;
					REG_DEVSEL: next_s.rdata[STAT_SUB_LSB +: 3] = s.subcnt;
					REG_STATUS: begin
						next_s.rdata[STAT_DP_LSB +: 7]  = s.dp;
						next_s.rdata[STAT_SUB_LSB +: 3] = s.subcnt;
						next_s.rdata[STAT_NACK_BIT]     = s.nack;
						next_s.rdata[STAT_EXT_BIT]      = s.osc_sel_s2;
						next_s.rdata[STAT_ROW_LSB +: 2] = s.row;
					end
					default: ;
				endcase
			end else begin
				unique case (AVS_REQ_I.address)
					REG_CTRL: begin
						next_s.mode     = lcm_mode_t'(AVS_REQ_I.writedata[CTRL_MODE_LSB +: 2]);
						next_s.last_dev = AVS_REQ_I.writedata[CTRL_LAST_BIT];
					end
					REG_DPTR: begin
						// pointers past the last column are folded back in range
						next_s.dp = (AVS_REQ_I.writedata[6:0] >= COLS_8[6:0]) ?
						            AVS_REQ_I.writedata[6:0] - COLS_8[6:0] : AVS_REQ_I.writedata[6:0];
					end
					REG_DEVSEL: next_s.subcnt = AVS_REQ_I.writedata[2:0];
					REG_DATA: begin
						// scatter the byte MSB first, nb rows per column
						for (int j = 0; j < 8; j++) begin
							col = {1'b0, s.dp} + 8'(j / nb);
							sub = s.subcnt;
							if (col >= COLS_8) begin
								col     = col - COLS_8;
								sub     = s.subcnt + 3'h1;
								wrapped = 1'b1;
							end
							// wrapped bits go to the next subaddress: a last driver's overflow has no owner
							if (sub == s.hw_s2) begin
								next_s.ram[col[6:0]][2'(j % nb)] = AVS_REQ_I.writedata[7-j];
							end
						end
						hit         = (s.subcnt == s.hw_s2);
						next_s.nack = hit && wrapped && s.last_dev;
						// pointer moves whether or not the byte was ours
						sum = {1'b0, s.dp} + 8'((s.mode == MODE_STATIC) ? 8 : (s.mode == MODE_MUX2) ? 4 :
						                        (s.mode == MODE_MUX3) ? 3 : 2);
						if (sum >= COLS_8) begin
							next_s.dp     = 7'(sum - COLS_8);
							next_s.subcnt = s.subcnt + 3'h1;
						end else begin
							next_s.dp = sum[6:0];
						end
					end
					default: ;                                  // unmapped writes are dropped
				endcase
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// state register; clock enable freezes everything
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			s <= STATE_RST;
		end else if (CE_I) begin
			s <= next_s;
		end
	end

	// outputs straight from the state register; sync data tied low
	assign AVS_READDATA_O    = s.rdata;
	assign AVS_WAITREQUEST_O = s.waitreq;
	assign CLK_PIN_O         = s.clk_out;
	assign CLK_PIN_OE_O      = s.clk_oe;
	assign SYNC_N_PIN_O      = 1'b0;                            // open drain: only ever pulls low
	assign SYNC_N_PIN_OE_O   = s.sync_oe;
	assign BACKPLANE_LINE_O  = s.bp;
	assign SEGMENT_LINE_O    = s.seg;
	assign FRAME_RATE_O      = s.frame;

	//////////////////////////////////////////////////////////////////////////
	// checks
	logic data_acc;
	assign data_acc = CE_I && s.waitreq && AVS_REQ_I.write && !AVS_REQ_I.read && AVS_REQ_I.address == REG_DATA;

	osc_drive_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		(CE_I && !s.osc_sel_s2) |=> s.clk_oe)
		else $error("clock pin not driven in internal oscillator mode");

	ext_clock_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		(CE_I && s.osc_sel_s2) |=> !s.clk_oe)
		else $error("clock pin driven in external clock mode");

	frame_phase_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		(CE_I && s.phase == PHASE_MAX && s.osc_sel_s2 && s.clk_s2 && !s.clk_prev) |=> s.phase == 5'h00)
		else $error("frame did not wrap after 24 clock ticks");

	sync_pull_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		($past(RESETN_I) && $past(CE_I))
		|-> (s.sync_oe == (s.phase == 5'h00) && s.frame == (s.phase < PHASE_HALF)))
		else $error("sync pull or frame level out of step with phase");

	mux3_pair_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		(CE_I && s.mode == MODE_MUX3) |=> (s.bp[3] == s.bp[1] && s.bp != 4'h0))
		else $error("three-backplane line 3 differs from line 1");

	mux2_pair_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		(CE_I && s.mode == MODE_MUX2) |=> (s.bp[2] == s.bp[0] && s.bp[3] == s.bp[1] && s.bp[0] != s.bp[1]))
		else $error("two-backplane pairs do not match");

	static_all_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		(CE_I && s.mode == MODE_STATIC) |=> s.bp == 4'hf)
		else $error("static backplane lines differ");

	ptr_step_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		(data_acc && s.mode == MODE_MUX3 && s.dp < 7'h4d) |=> s.dp == $past(s.dp) + 7'h03)
		else $error("pointer did not advance by three");

	sub_wrap_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		(data_acc && s.mode == MODE_MUX4 && s.dp >= 7'h4e) |=> s.subcnt == $past(s.subcnt) + 3'h1)
		else $error("subaddress counter did not advance on overflow");

	discard_keep_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		(data_acc && s.subcnt != s.hw_s2 && s.dp < 7'h48) |=> s.ram == $past(s.ram))
		else $error("byte stored although subaddress did not match");

	osc_div_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		(CE_I && !s.osc_sel_s2 && s.osc_cnt == 11'(OSC_TICK_CYC - 1)) |=> s.div_cnt == $past(s.div_cnt) + 6'h01)
		else $error("oscillator divider did not step");

	ext_step_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		(CE_I && s.osc_sel_s2 && s.clk_s2 && !s.clk_prev && s.phase != PHASE_MAX)
		|=> s.phase == $past(s.phase) + 5'h01)
		else $error("external clock rise did not step the frame phase");

	row_onehot_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		(CE_I && s.mode == MODE_MUX4) |=> s.bp == (4'h1 << s.row))
		else $error("four-backplane line does not match the shown row");

	ptr_load_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		(CE_I && s.waitreq && AVS_REQ_I.write && !AVS_REQ_I.read && AVS_REQ_I.address == REG_DPTR &&
		 AVS_REQ_I.writedata[6:0] < COLS_8[6:0]) |=> s.dp == $past(AVS_REQ_I.writedata[6:0]))
		else $error("data pointer not loaded");

	match_store_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		(data_acc && s.mode == MODE_STATIC && s.subcnt == s.hw_s2 && s.dp < 7'h48)
		|=> s.ram[$past(s.dp)][0] == $past(AVS_REQ_I.writedata[7]))
		else $error("first bit of a matching byte not stored at the pointer");

	static_step_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		(data_acc && s.mode == MODE_STATIC && s.dp < 7'h48) |=> s.dp == $past(s.dp) + 7'h08)
		else $error("pointer did not advance by eight");

	mux2_step_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		(data_acc && s.mode == MODE_MUX2 && s.dp < 7'h4c) |=> s.dp == $past(s.dp) + 7'h04)
		else $error("pointer did not advance by four");

	mux4_step_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		(data_acc && s.mode == MODE_MUX4 && s.dp < 7'h4e) |=> s.dp == $past(s.dp) + 7'h02)
		else $error("pointer did not advance by two");

	mux3_keep_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		(data_acc && s.mode == MODE_MUX3 && s.dp < 7'h4d)
		|=> s.ram[$past(s.dp) + 7'h02][3] == $past(s.ram[s.dp + 7'h02][3]))
		else $error("three-backplane byte touched row 3 of its last column");

	nack_set_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		(data_acc && s.last_dev && s.subcnt == s.hw_s2 && s.mode == MODE_STATIC && s.dp > 7'h48) |=> s.nack)
		else $error("overflow of a last driver was not refused");

	nack_clear_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		(data_acc && !s.last_dev) |=> !s.nack)
		else $error("byte refused by a driver that is not last");

	bus_answer_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		(CE_I && s.waitreq && (AVS_REQ_I.read || AVS_REQ_I.write)) |=> !s.waitreq)
		else $error("bus access not answered in the next cycle");

	bus_single_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		(CE_I && !s.waitreq) |=> s.waitreq)
		else $error("bus answer held for more than one cycle");

endmodule : lcm_core
`default_nettype wire

// ### inc/lcm_pkg.sv
/*
 * Shared constants and types of the LCD timing and display-memory core:
 * register map, field positions, reset values, timing counts, drive modes,
 * the Avalon-MM request carrier and the core's state record.
 * Assumes a 100 MHz system clock.
 */
`default_nettype none
package lcm_pkg;

	//////////////////////////////////////////////////////////////////////////
	// timing
	localparam int SYS_CLK_HZ   = 100000000;            // system clock rate
	localparam int OSC_PRE_DIV  = 64;                   // oscillator to internal clock
	localparam int FRAME_DIV    = 24;                   // internal clock to frame rate
	localparam int NOM_CLK_HZ   = 1536;                 // nominal internal clock
	localparam int OSC_TICK_CYC = SYS_CLK_HZ / (NOM_CLK_HZ * OSC_PRE_DIV); // cycles per oscillator period

	//////////////////////////////////////////////////////////////////////////
	// display memory geometry
	localparam int         NUM_COLS  = 80;
	localparam int         NUM_ROWS  = 4;
	localparam logic [7:0] COLS_8    = 8'h50;           // column count at 8-bit pointer-sum width
	localparam logic [4:0] PHASE_MAX = 5'h17;           // last phase of a frame
	localparam logic [4:0] PHASE_HALF = 5'h0c;          // frame signal falls here

	//////////////////////////////////////////////////////////////////////////
	// register map (byte addresses, one word each)
	localparam logic [4:0] REG_CTRL   = 5'h00;
	localparam logic [4:0] REG_DPTR   = 5'h04;
	localparam logic [4:0] REG_DEVSEL = 5'h08;
	localparam logic [4:0] REG_DATA   = 5'h0c;
	localparam logic [4:0] REG_STATUS = 5'h10;

	// field positions
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_LAST_BIT = 2;
	localparam int STAT_DP_LSB   = 0;
	localparam int STAT_SUB_LSB  = 8;
	localparam int STAT_NACK_BIT = 12;
	localparam int STAT_EXT_BIT  = 13;
	localparam int STAT_ROW_LSB  = 16;

	//////////////////////////////////////////////////////////////////////////
	// drive modes, in control register encoding order
	typedef enum logic [1:0] {MODE_STATIC, MODE_MUX2, MODE_MUX3, MODE_MUX4} lcm_mode_t;

	// Avalon-MM request from the master
	typedef struct packed {
		logic        read;
		logic        write;
		logic [4:0]  address;
		logic [31:0] writedata;
	} lcm_avm_req_t;

	// whole state of the core
	typedef struct packed {
		logic                               osc_sel_s1, osc_sel_s2;
		logic                               clk_s1, clk_s2, clk_prev;
		logic                               sync_s1, sync_s2, sync_prev;
		logic [2:0]                         hw_s1, hw_s2;
		logic [10:0]                        osc_cnt;
		logic [5:0]                         div_cnt;
		logic [4:0]                         phase;
		logic [1:0]                         row;
		lcm_mode_t                          mode;
		logic                               last_dev;
		logic [6:0]                         dp;
		logic [2:0]                         subcnt;
		logic                               nack;
		logic [NUM_COLS-1:0][NUM_ROWS-1:0]  ram;
		logic [NUM_COLS-1:0]                seg;
		logic [NUM_ROWS-1:0]                bp;
		logic                               frame;
		logic                               clk_out, clk_oe, sync_oe;
		logic                               waitreq;
		logic [31:0]                        rdata;
	} lcm_state_t;

	// reset values
	localparam lcm_mode_t  MODE_RST  = MODE_MUX4;
	localparam lcm_state_t STATE_RST = '{mode: MODE_RST, waitreq: 1'b1, default: '0};

endpackage : lcm_pkg
`default_nettype wire

// ### dv/lcm_peer.sv
/*
 * cascade neighbour of the LCD core: free-running clock source for the
 * clock pin and an open-drain puller on the shared sync wire.
 * assumes the bench resolves both wires from every party's enable.
 */
`timescale 1ns/1ps
`default_nettype none
module lcm_peer #(
	parameter int HALF = 10
) (
	input  wire logic clk_i,
	input  wire logic pull_go_i,
	output logic      clk_o,
	output logic      pull_o
);
	logic [7:0] cnt  = '0;
	logic [1:0] hold = '0;
	initial clk_o = 1'b0;

	//////////////////////////////////////////////////////////////////////
	// clock never stops: a halted clock would leave the panel at dc
	always @(posedge clk_i) begin
		cnt <= (cnt == 8'(HALF - 1)) ? 8'h00 : cnt + 8'h01;
		if (cnt == 8'(HALF - 1)) clk_o <= ~clk_o;
		hold <= pull_go_i ? 2'h3 : ((hold != 2'h0) ? hold - 2'h1 : hold);
	end
	// wire pulled low only for a short pulse, as a neighbour's frame start
	assign pull_o = (hold != 2'h0);
endmodule : lcm_peer
`default_nettype wire

// ### dv/lcm_core_test.sv
/*
 * self-checking bench of the LCD timing and display-memory core.
 * assumes the core answers each Avalon access one cycle after taking it.
 */
`timescale 1ns/1ps
`default_nettype none
module lcm_core_test;
	import lcm_pkg::*;
	logic         clk = 1'b0;
	logic         rst_n = 1'b0;
	lcm_avm_req_t req = '0;
	logic         osc_sel = 1'b0;
	logic [2:0]   straps = 3'h0;
	logic         pull_go = 1'b0;
	logic [31:0]  rdata, readdata;
	logic         waitreq, clk_o, clk_oe, sync_o, sync_oe, frame, peer_clk, peer_pull;
	logic [3:0]   bp;
	logic [79:0]  seg;
	wire logic    clk_pin = clk_oe ? clk_o : peer_clk;
	wire logic    sync_n = ~((sync_oe & ~sync_o) | peer_pull);
	int           bad_count = 0;
	int           tests_run = 0;

	initial begin
		forever #5 clk = ~clk;
	end

	lcm_core uut (.SYS_CLK_I(clk), .RESETN_I(rst_n), .CE_I(1'b1), .AVS_REQ_I(req),
		.AVS_READDATA_O(readdata), .AVS_WAITREQUEST_O(waitreq), .OSC_SEL_I(osc_sel),
		.CLK_PIN_I(clk_pin), .CLK_PIN_O(clk_o), .CLK_PIN_OE_O(clk_oe), .SYNC_N_PIN_I(sync_n),
		.SYNC_N_PIN_O(sync_o), .SYNC_N_PIN_OE_O(sync_oe), .HW_SUBADDR_I(straps),
		.BACKPLANE_LINE_O(bp), .SEGMENT_LINE_O(seg), .FRAME_RATE_O(frame));
	lcm_peer #(.HALF(10)) peer (.clk_i(clk), .pull_go_i(pull_go), .clk_o(peer_clk), .pull_o(peer_pull));

	//////////////////////////////////////////////////////////////////////
	// shared helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// one Avalon access; the request is held until waitrequest is seen low
	// no local limit: only the watchdog ends a wait that never gets its answer
	task automatic bus(input logic rd, input logic [4:0] a, input logic [31:0] wd);
		req <= '{read: rd, write: ~rd, address: a, writedata: wd};
		@(posedge clk);
		while (waitreq !== 1'b0) begin
			@(posedge clk);
		end
		rdata = readdata;
		req.read <= 1'b0;
		req.write <= 1'b0;
		@(posedge clk);
	endtask : bus

	task automatic reset_dut();
		rst_n <= 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
	endtask : reset_dut

	// lands well after the core has stepped on an external clock rise
	task automatic tick();
		@(posedge peer_clk);
		repeat (10) @(posedge clk);
	endtask : tick

	function automatic int row_of(input logic [3:0] b);
		return b[0] ? 0 : (b[1] ? 1 : (b[2] ? 2 : 3));
	endfunction : row_of

	function automatic logic bp_ok(input int m, input logic [3:0] b);
		case (m)
			0: return b == 4'hf;
			1: return b == 4'h5 || b == 4'ha;
			2: return b == 4'h1 || b == 4'ha || b == 4'h4;
			default: return $onehot(b);
		endcase
	endfunction : bp_ok

	// bit 7 first, column j/n, row j%n, pointer at 0
	function automatic logic [7:0] exp_seg(input int n, input logic [7:0] d, input int r);
		logic [7:0] s;
		s = '0;
		for (int j = 0; j < 8; j++)
			if (j % n == r) s[j / n] = d[7 - j];
		return s;
	endfunction : exp_seg

	//////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_clock();
		int n;
		n = 0;
		chk(clk_oe, 1);
		while (clk_o !== 1'b1 && n < 70000) begin
			@(posedge clk);
			n++;
		end
		n = 0;
		while (clk_o === 1'b1 && n < 70000) begin
			@(posedge clk);
			n++;
		end
		chk(n, OSC_PRE_DIV / 2 * OSC_TICK_CYC);
		osc_sel <= 1'b1;
		repeat (4) @(posedge clk);
		bus(1, REG_STATUS, 32'h0);
		chk({clk_oe, rdata[13]}, 32'h1);
	endtask : t_clock

	task automatic t_modes();
		int step [4] = '{8, 4, 3, 2};
		int highs;
		int rows;
		for (int m = 0; m < 4; m++) begin
			reset_dut();
			bus(0, REG_CTRL, 32'(m));
			bus(0, REG_DPTR, 32'h0);
			bus(0, REG_DATA, 32'hb4);
			bus(1, REG_STATUS, 32'h0);
			chk(rdata[6:0], 32'(step[m]));
			highs = 0;
			rows = 0;
			for (int t = 0; t < 24; t++) begin
				tick();
				highs += int'(frame);
				rows |= 1 << row_of(bp);
				chk(bp_ok(m, bp), 1);
				chk(seg[7:0], exp_seg(m + 1, 8'hb4, row_of(bp)));
			end
			chk(highs, 12);
			chk(rows, (1 << (m + 1)) - 1);
		end
	endtask : t_modes

	// a neighbour's frame start mid-frame pulls this core back to phase 0
	task automatic t_sync();
		int n;
		n = 0;
		while (frame !== 1'b0 && n < 30) begin
			tick();
			n++;
		end
		pull_go <= 1'b1;
		@(posedge clk);
		pull_go <= 1'b0;
		repeat (6) @(posedge clk);
		chk({sync_oe, frame}, 32'h3);
	endtask : t_sync

	task automatic t_cascade();
		reset_dut();
		bus(0, REG_CTRL, 32'h0);
		bus(0, REG_DEVSEL, 32'h1);
		bus(0, REG_DPTR, 32'h8);
		bus(0, REG_DATA, 32'hff);
		bus(1, REG_STATUS, 32'h0);
		chk(seg[15:8], 32'h0);
		chk(rdata[10:0], 32'h110);
		bus(0, REG_DEVSEL, 32'h0);
		bus(0, REG_DPTR, 32'h4c);
		bus(0, REG_DATA, 32'hff);
		bus(1, REG_STATUS, 32'h0);
		chk({seg[79:76], seg[3:0]}, 32'hf0);
		chk(rdata[12:0], 32'h104);
		straps <= 3'h1;
		repeat (4) @(posedge clk);
		bus(0, REG_DEVSEL, 32'h0);
		bus(0, REG_DPTR, 32'h4c);
		bus(0, REG_DATA, 32'h0f);
		chk({seg[79:76], seg[3:0]}, 32'hff);
		straps <= 3'h0;
		repeat (4) @(posedge clk);
		bus(0, REG_CTRL, 32'h4);
		bus(0, REG_DEVSEL, 32'h0);
		bus(0, REG_DPTR, 32'h4c);
		bus(0, REG_DATA, 32'h00);
		bus(1, REG_STATUS, 32'h0);
		chk(rdata[12], 1);
		chk({seg[79:76], seg[3:0]}, 32'h0f);
		// a last driver still takes what overflows from the driver before it
		straps <= 3'h1;
		repeat (4) @(posedge clk);
		bus(0, REG_DEVSEL, 32'h0);
		bus(0, REG_DPTR, 32'h4c);
		bus(0, REG_DATA, 32'h0a);
		bus(1, REG_STATUS, 32'h0);
		chk(seg[3:0], 32'h5);
		chk(rdata[12], 0);
		bus(1, 5'h14, 32'h0);
		chk(rdata, 32'h0);
	endtask : t_cascade

	//////////////////////////////////////////////////////////////////////
	// verdict, reached from the main sequence or the watchdog
	task automatic results();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : results

	initial begin
		reset_dut();
		t_clock();
		t_modes();
		t_sync();
		t_cascade();
		results();
	end

	// the slow oscillator period dominates, about 68k cycles expected in all
	initial begin
		#900000;
		bad_count++;
		results();
	end
endmodule : lcm_core_test
`default_nettype wire
